/* File: branch_and_system_ctrl_exec.sv */
// How it works
// [RULE1] Bit clear reads the byte, clears one bit, writes the byte back.
// [RULE2] The write-only direction register reads as all ones.
// [RULE3] Direction bit 0 makes the pin an input.
// [RULE4] Direction bit 1 makes the pin drive its output data bit.
// [RULE5] Conditional jump branches when its condition is true; 0000 always, 0001 never.
// [RULE6] Unsigned codes 0010-0101 test C or Z, and C alone.
// [RULE7] Signed codes 1100-1111 test N xor V, and Z or N xor V.
// [RULE8] Codes 0110-1011 test Z, V and N for zero and one.
// [RULE9] Goto loads the address; relative call saves return and adds displacement.
// [RULE10] Absolute call saves the return address and jumps to the address.
// [RULE11] Return from call restores the saved return address.
// [RULE12] Return from exception restores the saved flags and program counter.
// [RULE13] Sleep leaves execution and enters power-down.
// [RULE14] Load flags takes an immediate byte or a general register.
// [RULE15] Store flags copies flags into a general register, flags unchanged.
// [RULE16] And-flags replaces flags with flags AND immediate.
// [RULE17] Or-flags replaces flags with flags OR immediate.
// [RULE18] Xor-flags replaces flags with flags XOR immediate.
// [RULE19] Idle op only adds two to the program counter.
// [RULE20] Bit set, clear, invert, store and inverted store are read-modify-write.

`include "branch_exec_params.svh"

module branch_and_system_ctrl_exec #(
   parameter int NUM_GPR     = 8,
   parameter int STACK_DEPTH = 8,
   parameter int RAM_BYTES   = 16
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Port pins
   input  wire logic [7:0]  port_pin_in,
   output logic      [7:0]  port_pin_out,
   output logic      [7:0]  port_pin_oe,
   // Power-down indication
   output logic             sleeping
);
   import branch_exec_pkg::*;

   localparam int SPW = $clog2(STACK_DEPTH);
   localparam int RAW = $clog2(RAM_BYTES);
   localparam int GPW = $clog2(NUM_GPR);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   state_t              state_r;
   state_t              state_nxt;
   logic [15:0]         pc_r;
   logic [15:0]         pc_nxt;
   logic [7:0]          flags_r;
   logic [7:0]          flags_nxt;
   logic [31:0]         cmd_r;
   logic [15:0]         opnd_r;
   logic [7:0]          gpr_r [NUM_GPR];
   logic [23:0]         stk_r [STACK_DEPTH];
   logic [7:0]          ram_r [RAM_BYTES];
   logic [SPW-1:0]      sp_r;
   logic                taken_r;
   logic                taken_nxt;
   logic [7:0]          mod_r;
   logic                push;
   logic                pop;
   logic                gpr_we;

   byte_bus_if          bbus ();

   // ----------------------------------------------------------------------
   // Condition evaluation
   // ----------------------------------------------------------------------
   function automatic logic cond_eval(input logic [3:0] cf, input logic [7:0] f);
      logic c;
      logic z;
      logic n;
      logic v;
      c = f[`FLAG_C];
      z = f[`FLAG_Z];
      n = f[`FLAG_N];
      v = f[`FLAG_V];
      case (cf)
         4'h0: cond_eval = 1'b1;             // [RULE5]
         4'h1: cond_eval = 1'b0;             // [RULE5]
         4'h2: cond_eval = ~(c | z);         // [RULE6]
         4'h3: cond_eval = c | z;            // [RULE6]
         4'h4: cond_eval = ~c;               // [RULE6]
         4'h5: cond_eval = c;                // [RULE6]
         4'h6: cond_eval = ~z;               // [RULE8]
         4'h7: cond_eval = z;                // [RULE8]
         4'h8: cond_eval = ~v;               // [RULE8]
         4'h9: cond_eval = v;                // [RULE8]
         4'ha: cond_eval = ~n;               // [RULE8]
         4'hb: cond_eval = n;                // [RULE8]
         4'hc: cond_eval = ~(n ^ v);         // [RULE7]
         4'hd: cond_eval = n ^ v;            // [RULE7]
         4'he: cond_eval = ~(z | (n ^ v));   // [RULE7]
         default: cond_eval = z | (n ^ v);   // [RULE7]
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // Command fields
   // ----------------------------------------------------------------------
   op_t         op;
   logic [3:0]  cond_field;
   logic [2:0]  bit_no;
   logic [GPW-1:0] reg_sel;
   logic [7:0]  imm;
   logic [15:0] pc_seq;
   logic [15:0] pc_rel;
   logic        is_bit_op;

   assign op         = op_t'(cmd_r[`CMD_OP_LSB +: 5]);
   assign cond_field = cmd_r[`CMD_COND_LSB +: 4];
   assign bit_no     = cmd_r[`CMD_COND_LSB +: 3];
   assign reg_sel    = cmd_r[`CMD_REG_LSB +: GPW];
   assign imm        = cmd_r[`CMD_IMM_LSB +: 8];
   assign pc_seq     = pc_r + `PC_STEP;
   // Displacement is the signed immediate byte of the command, added to the next address
   assign pc_rel     = pc_seq + {{8{imm[7]}}, imm};
   assign is_bit_op  = (op == OP_BIT_SET) || (op == OP_BIT_CLEAR) || (op == OP_BIT_INVERT)
                       || (op == OP_BIT_STORE) || (op == OP_BIT_ISTORE);

   // ----------------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------------
   logic        setup;
   logic        wr_go;
   logic        hit_cmd;
   logic        hit_opnd;
   logic        hit_pc;
   logic        hit_flags;
   logic        hit_status;
   logic        hit_wake;
   logic        hit_gpr;
   logic        mapped;
   logic [GPW-1:0] gpr_idx;
   logic        idle;
   logic [31:0] status_word;
   logic [31:0] rd_mux;

   assign setup      = psel & ~penable;
   assign wr_go      = psel & penable & pwrite & pready;
   assign hit_cmd    = paddr == `OFS_CMD;
   assign hit_opnd   = paddr == `OFS_OPND;
   assign hit_pc     = paddr == `OFS_PC;
   assign hit_flags  = paddr == `OFS_FLAGS;
   assign hit_status = paddr == `OFS_STATUS;
   assign hit_wake   = paddr == `OFS_WAKE;
   assign hit_gpr    = (paddr[7:5] == `GPR_PAGE) && (paddr[1:0] == 2'h0)
                       && (32'(paddr[4:2]) < NUM_GPR);
   assign gpr_idx    = paddr[2 +: GPW];
   assign mapped     = hit_cmd | hit_opnd | hit_pc | hit_flags | hit_status | hit_wake | hit_gpr;
   assign idle       = state_r == ST_IDLE;
   assign status_word = {16'h0000, 8'(sp_r), 5'h00,
                         taken_r, state_r == ST_SLEEP, ~idle};

   // Read data selection
   assign rd_mux = hit_cmd    ? cmd_r :
                   hit_opnd   ? {16'h0000, opnd_r} :
                   hit_pc     ? {16'h0000, pc_r} :
                   hit_flags  ? {24'h000000, flags_r} :
                   hit_status ? status_word :
                   hit_gpr    ? {24'h000000, gpr_r[gpr_idx]} : 32'h00000000;

   // Answer registered in setup, ready for one access cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         prdata  <= setup ? rd_mux : prdata;
      end
   end

   // ----------------------------------------------------------------------
   // Internal byte bus and read-modify-write data
   // ----------------------------------------------------------------------
   logic [7:0] rd_byte;
   logic [7:0] bit_mask;
   logic [7:0] mod_byte;

   assign bbus.addr  = opnd_r;
   assign bbus.wdata = mod_r;
   assign bbus.we    = (state_r == ST_WRITE) & bbus.hit;
   assign rd_byte    = bbus.hit ? bbus.rdata : ram_r[opnd_r[RAW-1:0]]; // [RULE20]
   assign bit_mask   = 8'h01 << bit_no;

   // Modify one bit of the byte just read
   always_comb begin
      case (op)
         OP_BIT_SET:    mod_byte = rd_byte | bit_mask;  // [RULE20]
         OP_BIT_CLEAR:  mod_byte = rd_byte & ~bit_mask; // [RULE1]
         OP_BIT_INVERT: mod_byte = rd_byte ^ bit_mask;  // [RULE20]
         OP_BIT_STORE:  mod_byte = flags_r[`FLAG_C] ? (rd_byte | bit_mask) : (rd_byte & ~bit_mask);
         default:       mod_byte = flags_r[`FLAG_C] ? (rd_byte & ~bit_mask) : (rd_byte | bit_mask);
      endcase
   end

   port_unit #(
      .WIDTH (8)
   ) u_port (
      .clk     (clk),
      .rst     (rst),
      .bus     (bbus.target),
      .pin_in  (port_pin_in),
      .pin_out (port_pin_out),
      .pin_oe  (port_pin_oe)
   );

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------
   // Execute one command and work out the next architectural state
   always_comb begin
      state_nxt = state_r;
      pc_nxt    = pc_r;
      flags_nxt = flags_r;
      taken_nxt = taken_r;
      push      = 1'b0;
      pop       = 1'b0;
      gpr_we    = 1'b0;
      case (state_r)
         ST_IDLE: begin
            if (wr_go && hit_cmd) begin
               state_nxt = ST_EXEC;
            end
         end
         ST_EXEC: begin
            state_nxt = ST_IDLE;
            pc_nxt    = pc_seq; // [RULE19]
            taken_nxt = 1'b0;
            case (op)
               OP_JUMP_COND: begin
                  taken_nxt = cond_eval(cond_field, flags_r); // [RULE5]
                  pc_nxt    = taken_nxt ? pc_rel : pc_seq;    // [RULE5]
               end
               OP_GOTO_ABS: begin
                  pc_nxt = opnd_r; // [RULE9]
               end
               OP_CALL_ABS: begin
                  push   = 1'b1;   // [RULE10]
                  pc_nxt = opnd_r; // [RULE10]
               end
               OP_CALL_REL: begin
                  push   = 1'b1;   // [RULE9]
                  pc_nxt = pc_rel; // [RULE9]
               end
               OP_RETURN_CALL: begin
                  pop    = 1'b1;
                  pc_nxt = stk_r[sp_r - 1'b1][15:0]; // [RULE11]
               end
               OP_RETURN_EXC: begin
                  pop       = 1'b1;
                  pc_nxt    = stk_r[sp_r - 1'b1][15:0];  // [RULE12]
                  flags_nxt = stk_r[sp_r - 1'b1][23:16]; // [RULE12]
               end
               OP_SLEEP: begin
                  state_nxt = ST_SLEEP; // [RULE13]
               end
               OP_LOAD_IMM:    flags_nxt = imm;              // [RULE14]
               OP_LOAD_REG:    flags_nxt = gpr_r[reg_sel];   // [RULE14]
               OP_STORE_FLAGS: gpr_we    = 1'b1;             // [RULE15]
               OP_AND_FLAGS:   flags_nxt = flags_r & imm;    // [RULE16]
               OP_OR_FLAGS:    flags_nxt = flags_r | imm;    // [RULE17]
               OP_XOR_FLAGS:   flags_nxt = flags_r ^ imm;    // [RULE18]
               default: begin
                  if (is_bit_op) begin
                     state_nxt = ST_READ; // [RULE20]
                  end
               end
            endcase
         end
         ST_READ: begin
            state_nxt = ST_WRITE; // [RULE20]
         end
         ST_WRITE: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            if (wr_go && hit_wake && pwdata[0]) begin
               state_nxt = ST_IDLE;
            end
         end
      endcase
   end

   // Sequencer state and power-down flag
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r  <= ST_IDLE;
         sleeping <= 1'b0;
         taken_r  <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         sleeping <= state_nxt == ST_SLEEP; // [RULE13]
         taken_r  <= taken_nxt;
      end
   end

   // Program counter, software may load it while idle
   always_ff @(posedge clk) begin
      if (rst) begin
         pc_r <= `PC_RST;
      end else if (idle && wr_go && hit_pc) begin
         pc_r <= pwdata[15:0];
      end else begin
         pc_r <= pc_nxt;
      end
   end

   // Flags register, software may load it while idle
   always_ff @(posedge clk) begin
      if (rst) begin
         flags_r <= `FLAGS_RST;
      end else if (idle && wr_go && hit_flags) begin
         flags_r <= pwdata[7:0];
      end else begin
         flags_r <= flags_nxt;
      end
   end

   // Command and operand, accepted only while idle
   always_ff @(posedge clk) begin
      if (rst) begin
         cmd_r  <= 32'h00000000;
         opnd_r <= 16'h0000;
      end else if (idle && wr_go) begin
         cmd_r  <= hit_cmd ? pwdata : cmd_r;
         opnd_r <= hit_opnd ? pwdata[15:0] : opnd_r;
      end
   end

   // Return stack: flags and return address saved together
   always_ff @(posedge clk) begin
      if (rst) begin
         sp_r <= '0;
      end else if (push) begin
         stk_r[sp_r] <= {flags_r, pc_seq}; // [RULE9] [RULE10]
         sp_r        <= sp_r + 1'b1;
      end else if (pop) begin
         sp_r <= sp_r - 1'b1; // [RULE11] [RULE12]
      end
   end

   // General registers: software writes while idle, store-flags writes
   always_ff @(posedge clk) begin
      if (gpr_we) begin
         gpr_r[reg_sel] <= flags_r; // [RULE15]
      end else if (idle && wr_go && hit_gpr) begin
         gpr_r[gpr_idx] <= pwdata[7:0];
      end
   end

   // Modified byte held between read and write
   always_ff @(posedge clk) begin
      if (rst) begin
         mod_r <= 8'h00;
      end else if (state_r == ST_READ) begin
         mod_r <= mod_byte; // [RULE1] [RULE20]
      end
   end

   // Scratch memory for bit operations outside the port
   always_ff @(posedge clk) begin
      if (state_r == ST_WRITE && !bbus.hit) begin
         ram_r[opnd_r[RAW-1:0]] <= mod_r; // [RULE1] [RULE20]
      end
   end

endmodule

/* File: branch_exec_params.svh */
`ifndef BRANCH_EXEC_PARAMS_SVH
`define BRANCH_EXEC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses on APB)
// ----------------------------------------------------------------------
`define OFS_CMD        8'h00
`define OFS_OPND       8'h04
`define OFS_PC         8'h08
`define OFS_FLAGS      8'h0c
`define OFS_STATUS     8'h10
`define OFS_WAKE       8'h14
`define GPR_PAGE       3'h1

// ----------------------------------------------------------------------
// Command register fields
// ----------------------------------------------------------------------
`define CMD_OP_LSB     0
`define CMD_COND_LSB   8
`define CMD_REG_LSB    12
`define CMD_IMM_LSB    16

// ----------------------------------------------------------------------
// Flag positions and reset values
// ----------------------------------------------------------------------
`define FLAG_C         0
`define FLAG_V         1
`define FLAG_Z         2
`define FLAG_N         3
`define FLAGS_RST      8'h80
`define PC_RST         16'h0000
`define PC_STEP        16'h0002

// ----------------------------------------------------------------------
// Internal byte bus map and port reset values
// ----------------------------------------------------------------------
`define PORT_DIR_ADDR  16'hfffd
`define PORT_DATA_ADDR 16'hffff
`define PORT_DIR_READ  8'hff
`define PORT_DIR_RST   8'h00
`define PORT_DATA_RST  8'h00

`endif

/* File: branch_exec_pkg.sv */
package branch_exec_pkg;

   // Operations issued through the command register
   typedef enum logic [4:0] {
      OP_IDLE        = 5'h00,
      OP_JUMP_COND   = 5'h01,
      OP_GOTO_ABS    = 5'h02,
      OP_CALL_ABS    = 5'h03,
      OP_CALL_REL    = 5'h04,
      OP_RETURN_CALL = 5'h05,
      OP_RETURN_EXC  = 5'h06,
      OP_SLEEP       = 5'h07,
      OP_LOAD_IMM    = 5'h08,
      OP_LOAD_REG    = 5'h09,
      OP_STORE_FLAGS = 5'h0a,
      OP_AND_FLAGS   = 5'h0b,
      OP_OR_FLAGS    = 5'h0c,
      OP_XOR_FLAGS   = 5'h0d,
      OP_BIT_SET     = 5'h0e,
      OP_BIT_CLEAR   = 5'h0f,
      OP_BIT_INVERT  = 5'h10,
      OP_BIT_STORE   = 5'h11,
      OP_BIT_ISTORE  = 5'h12
   } op_t;

   // Sequencer states, Gray coded along idle-exec-read-write
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_EXEC  = 3'b001,
      ST_READ  = 3'b011,
      ST_WRITE = 3'b010,
      ST_SLEEP = 3'b110
   } state_t;

endpackage

/* File: byte_bus_if.sv */
// Internal byte bus between the sequencer and the port unit
interface byte_bus_if;
   logic [15:0] addr;
   logic [7:0]  wdata;
   logic        we;
   logic [7:0]  rdata;
   logic        hit;

   modport master (output addr, output wdata, output we, input rdata, input hit);
   modport target (input addr, input wdata, input we, output rdata, output hit);
endinterface

/* File: port_unit.sv */
`include "branch_exec_params.svh"

module port_unit #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Byte bus
   byte_bus_if.target            bus,
   // Port pins
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] pin_out,
   output logic      [WIDTH-1:0] pin_oe
);

   // ----------------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------------
   logic             sel_dir;
   logic             sel_data;
   logic [WIDTH-1:0] pin_view;

   assign sel_dir  = bus.addr == `PORT_DIR_ADDR;
   assign sel_data = bus.addr == `PORT_DATA_ADDR;
   assign bus.hit  = sel_dir | sel_data;

   // Output bits show the latch, input bits show the pin
   assign pin_view  = (pin_oe & pin_out) | (~pin_oe & pin_in); // [RULE3] [RULE4]
   // Direction register is write-only and always reads as all ones
   assign bus.rdata = sel_dir ? `PORT_DIR_READ : (sel_data ? pin_view : 8'h00); // [RULE2]

   // ----------------------------------------------------------------------
   // Direction and output latches
   // ----------------------------------------------------------------------
   // Direction bit 1 drives the pin from the latch, 0 leaves it an input
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_oe <= `PORT_DIR_RST;
      end else if (bus.we && sel_dir) begin
         pin_oe <= bus.wdata; // [RULE3] [RULE4]
      end
   end

   // Output data latch
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_out <= `PORT_DATA_RST;
      end else if (bus.we && sel_data) begin
         pin_out <= bus.wdata;
      end
   end

endmodule

/* File: branch_and_system_ctrl_exec_assertions.sv */
`include "branch_exec_params.svh"

module branch_exec_checker (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Port pins and power-down
   input wire logic [7:0]  port_pin_in,
   input wire logic [7:0]  port_pin_out,
   input wire logic [7:0]  port_pin_oe,
   input wire logic        sleeping
);
   import branch_exec_pkg::*;

   // Completed write decode
   wire acc_wr   = psel && penable && pready && pwrite;
   wire cmd_wr   = acc_wr && paddr == `OFS_CMD;
   wire sleep_wr = cmd_wr && pwdata[4:0] == OP_SLEEP;
   wire wake_wr  = acc_wr && paddr == `OFS_WAKE && pwdata[0];

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_single_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   err_read_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   sleep_entry_a: assert property ($rose(sleeping) |-> $past(sleep_wr, 2))
      else $error("sleep entered without sleep op");
   sleep_exit_a: assert property ($fell(sleeping) |-> $past(wake_wr))
      else $error("sleep left without wake");
   dir_rmw_a: assert property ($changed(port_pin_oe) |-> $past(cmd_wr, 4))
      else $error("direction changed outside bit op write back");
   data_rmw_a: assert property ($changed(port_pin_out) |-> $past(cmd_wr, 4))
      else $error("port data changed outside bit op write back");
   halt_hold_a: assert property (sleeping && $past(sleeping) |->
      $stable(port_pin_oe) && $stable(port_pin_out))
      else $error("port changed while halted");
endmodule

bind branch_and_system_ctrl_exec branch_exec_checker checker_u (
   .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .port_pin_in(port_pin_in), .port_pin_out(port_pin_out),
   .port_pin_oe(port_pin_oe), .sleeping(sleeping)
);

/* File: branch_and_system_ctrl_exec_tb.sv */
`include "branch_exec_params.svh"

`define CHK(nm, e, g) begin \
   n_compared++; \
   if ((g) !== (e)) begin \
      mismatches++; \
      $display("MISMATCH %s expected %h seen %h", nm, e, g); \
   end \
end

module branch_and_system_ctrl_exec_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import branch_exec_pkg::*;

   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  port_pin_in = 8'h00;
   logic [7:0]  port_pin_out;
   logic [7:0]  port_pin_oe;
   logic        sleeping;
   logic [31:0] q;
   logic        e;
   int          mismatches = 0;
   int          n_compared = 0;
   int          cycles = 0;

   branch_and_system_ctrl_exec dut_u (
      .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .port_pin_in(port_pin_in), .port_pin_out(port_pin_out),
      .port_pin_oe(port_pin_oe), .sleeping(sleeping)
   );

   // Clock and hang guard
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles > 20000) begin
         mismatches++;
         results();
      end
   end

   // ----------------------------------------------------------------
   // Bus tasks
   // ----------------------------------------------------------------
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] x);
      apb(a, 1'b0, 32'h0);
      `CHK(nm, x, q)
   endtask

   // Issue one op and wait until idle
   task automatic run(input op_t op, input logic [3:0] cc, input logic [2:0] r,
                      input logic [7:0] imm, input logic [15:0] opnd);
      apb(`OFS_OPND, 1'b1, {16'h0, opnd});
      apb(`OFS_CMD, 1'b1, {8'h0, imm, 1'b0, r, cc, 3'h0, op});
      q = 32'h1;
      while (q[0] !== 1'b0) begin
         apb(`OFS_STATUS, 1'b0, 32'h0);
      end
   endtask

   // Expected branch decision
   function automatic logic cond_true(input logic [3:0] cc, input logic [3:0] f);
      logic c, v, z, n, x;
      c = f[`FLAG_C];
      v = f[`FLAG_V];
      z = f[`FLAG_Z];
      n = f[`FLAG_N];
      case (cc[3:1])
         3'd0: x = 1'b0;
         3'd1: x = c | z;
         3'd2: x = c;
         3'd3: x = z;
         3'd4: x = v;
         3'd5: x = n;
         3'd6: x = n ^ v;
         default: x = z | (n ^ v);
      endcase
      return x == cc[0];
   endfunction

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      rchk("pc", `OFS_PC, 32'h0);
      rchk("flags", `OFS_FLAGS, 32'h80);
      `CHK("oe", 8'h00, port_pin_oe)
      apb(8'h18, 1'b0, 32'h0);
      `CHK("unmapped err", 1'b1, e)
      `CHK("unmapped data", 32'h0, q)
   endtask

   task automatic t_cond;
      for (int cc = 0; cc < 16; cc++) begin
         for (int f = 0; f < 16; f++) begin
            apb(`OFS_PC, 1'b1, 32'h100);
            apb(`OFS_FLAGS, 1'b1, 32'(f));
            run(OP_JUMP_COND, cc[3:0], 3'h0, 8'hf0, 16'h0);
            e = cond_true(cc[3:0], f[3:0]);
            `CHK("taken", e, q[2])
            rchk("cond pc", `OFS_PC, e ? 32'hf2 : 32'h102);
         end
      end
   endtask

   task automatic t_flow;
      apb(`OFS_PC, 1'b1, 32'h200);
      apb(`OFS_FLAGS, 1'b1, 32'h05);
      run(OP_IDLE, 4'h0, 3'h0, 8'h00, 16'h0);
      rchk("idle pc", `OFS_PC, 32'h202);
      rchk("idle flags", `OFS_FLAGS, 32'h05);
      run(OP_GOTO_ABS, 4'h0, 3'h0, 8'h00, 16'h1234);
      rchk("goto pc", `OFS_PC, 32'h1234);
      run(OP_CALL_ABS, 4'h0, 3'h0, 8'h00, 16'h4000);
      rchk("call pc", `OFS_PC, 32'h4000);
      run(OP_LOAD_IMM, 4'h0, 3'h0, 8'h0a, 16'h0);
      run(OP_RETURN_EXC, 4'h0, 3'h0, 8'h00, 16'h0);
      rchk("rte pc", `OFS_PC, 32'h1236);
      rchk("rte flags", `OFS_FLAGS, 32'h05);
      run(OP_CALL_REL, 4'h0, 3'h0, 8'h10, 16'h0);
      rchk("bsr pc", `OFS_PC, 32'h1248);
      run(OP_RETURN_CALL, 4'h0, 3'h0, 8'h00, 16'h0);
      rchk("ret pc", `OFS_PC, 32'h1238);
   endtask

   task automatic t_flags;
      run(OP_LOAD_IMM, 4'h0, 3'h0, 8'h5a, 16'h0);
      rchk("ld imm", `OFS_FLAGS, 32'h5a);
      run(OP_AND_FLAGS, 4'h0, 3'h0, 8'h0f, 16'h0);
      rchk("and", `OFS_FLAGS, 32'h0a);
      run(OP_OR_FLAGS, 4'h0, 3'h0, 8'h30, 16'h0);
      rchk("or", `OFS_FLAGS, 32'h3a);
      run(OP_XOR_FLAGS, 4'h0, 3'h0, 8'hff, 16'h0);
      rchk("xor", `OFS_FLAGS, 32'hc5);
      apb(8'h2c, 1'b1, 32'h11);
      run(OP_LOAD_REG, 4'h0, 3'h3, 8'h00, 16'h0);
      rchk("ld reg", `OFS_FLAGS, 32'h11);
      run(OP_XOR_FLAGS, 4'h0, 3'h0, 8'h33, 16'h0);
      run(OP_STORE_FLAGS, 4'h0, 3'h5, 8'h00, 16'h0);
      rchk("st gpr", 8'h34, 32'h22);
      rchk("st flags", `OFS_FLAGS, 32'h22);
   endtask

   task automatic t_port;
      run(OP_BIT_CLEAR, 4'h0, 3'h0, 8'h00, `PORT_DIR_ADDR);
      `CHK("dir clr0", 8'hfe, port_pin_oe)
      run(OP_BIT_CLEAR, 4'h7, 3'h0, 8'h00, `PORT_DIR_ADDR);
      `CHK("dir clr7", 8'h7f, port_pin_oe)
      run(OP_BIT_SET, 4'h1, 3'h0, 8'h00, `PORT_DATA_ADDR);
      `CHK("out set1", 8'h02, port_pin_out)
      port_pin_in <= 8'h80;
      run(OP_BIT_INVERT, 4'h0, 3'h0, 8'h00, `PORT_DATA_ADDR);
      `CHK("out inv0", 8'h83, port_pin_out)
      apb(`OFS_FLAGS, 1'b1, 32'h01);
      run(OP_BIT_STORE, 4'h2, 3'h0, 8'h00, `PORT_DATA_ADDR);
      `CHK("out st2", 8'h87, port_pin_out)
      run(OP_BIT_ISTORE, 4'h2, 3'h0, 8'h00, `PORT_DATA_ADDR);
      `CHK("out ist2", 8'h83, port_pin_out)
   endtask

   task automatic t_sleep;
      int n;
      n = 0;
      apb(`OFS_CMD, 1'b1, {27'h0, OP_SLEEP});
      while (sleeping !== 1'b1 && n < 10) begin
         n++;
         @(posedge clk);
      end
      `CHK("sleeping", 1'b1, sleeping)
      apb(`OFS_STATUS, 1'b0, 32'h0);
      `CHK("status sleep", 1'b1, q[1])
      apb(`OFS_WAKE, 1'b1, 32'h1);
      n = 0;
      while (sleeping !== 1'b0 && n < 10) begin
         n++;
         @(posedge clk);
      end
      `CHK("woken", 1'b0, sleeping)
   endtask

   // ----------------------------------------------------------------
   // Verdict
   // ----------------------------------------------------------------
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_cond();
      t_flow();
      t_flags();
      t_port();
      t_sleep();
      results();
   end
endmodule
